// ### core/gica_pkg.sv
// Shared constants and carrier types for the guest indirect register window
package gica_pkg;

	// ----------------------------------------------------------------
	// Register numbers
	// ----------------------------------------------------------------
	localparam logic [11:0] GICA_G_SEL  = 12'h250;
	localparam logic [11:0] GICA_G_AL1  = 12'h251;
	localparam logic [11:0] GICA_G_AL2  = 12'h252;
	localparam logic [11:0] GICA_G_AL3  = 12'h253;
	localparam logic [11:0] GICA_G_AL4  = 12'h255;
	localparam logic [11:0] GICA_G_AL5  = 12'h256;
	localparam logic [11:0] GICA_G_AL6  = 12'h257;
	localparam logic [11:0] GICA_S_SEL  = 12'h150;
	localparam logic [11:0] GICA_S_AL1  = 12'h151;
	localparam logic [11:0] GICA_S_AL2  = 12'h152;
	localparam logic [11:0] GICA_S_AL3  = 12'h153;
	localparam logic [11:0] GICA_S_AL4  = 12'h155;
	localparam logic [11:0] GICA_S_AL5  = 12'h156;
	localparam logic [11:0] GICA_S_AL6  = 12'h157;

	// ----------------------------------------------------------------
	// Field positions, codes and reset values
	// ----------------------------------------------------------------
	localparam int          GICA_SEL_MIN_BITS = 12;
	localparam int          GICA_TOP64        = 63;
	localparam int          GICA_TOP32        = 31;
	localparam int          GICA_NUM_ALIAS    = 6;
	localparam logic [1:0]  GICA_PRIV_U       = 2'h0;
	localparam logic [1:0]  GICA_PRIV_S       = 2'h1;
	localparam logic [1:0]  GICA_PRIV_M       = 2'h3;
	localparam logic        GICA_RST_CUST     = 1'h0;
	localparam logic [63:0] GICA_RST_DATA     = 64'h0;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic        valid;
		logic        write;
		logic [11:0] num;
		logic [63:0] wdata;
		logic [1:0]  priv;
		logic        virt;
		logic        xlen64;
	} gica_req_t;

	typedef struct packed {
		logic        valid;
		logic        hit;
		logic        illegal;
		logic        virt_exc;
		logic [63:0] rdata;
	} gica_rsp_t;

endpackage

// ### core/gica_top.sv
// Guest indirect select and alias register window with access checks
// Notes on behaviour
// - Guest select register lives at 0x250, hypervisor read-write, current width.
// - Guest aliases one to three live at 0x251 to 0x253.
// - Guest aliases four to six live at 0x255 to 0x257.
// - With hypervisor present, guest copies replace supervisor pair while virtualised.
// - Guest select holds at least every value zero to 0xfff.
// - Select top bit set means custom; clear means standard, reserved.
// - On width change the select top bit moves and keeps its value.
// - Guest and supervisor select should share one bit count.
// - Guest direct access, or guest user supervisor access, gives virtual fault.
// - Usual hypervisor qualification test is not used for these aliases.
// - Alias access with unimplemented select value raises illegal instruction.
// - Implemented select value: alias access acts as owning extension defines.
// - Select implemented for hypervisor only: guest supervisor alias gives virtual fault.
// - Register width follows current width, not guest width.
// - Machine enable bit 60 gates all select and alias registers.
// - Machine bit 60 clear: access below machine mode is illegal.
// - Enable bits never restrict machine mode accesses.
// - Machine bit 60 set: guest virtual faults still apply.
// - Hypervisor bit 60 gates only supervisor pair as seen by guest.
// - Hypervisor bit clear, machine set: guest supervisor access gives virtual fault.
`timescale 1ns/10ps
`default_nettype none

module gica_top
	import gica_pkg::*;
#(
	parameter bit HYP_PRESENT  = 1'b1,
	parameter bit MSTATEEN_IMP = 1'b1,
	parameter bit HSTATEEN_IMP = 1'b1,
	parameter int SEL_BITS     = 12,
	parameter int IMPL_BASE    = 0,
	parameter int NUM_ENTRIES  = 4,
	parameter bit GUEST_IMPL   = 1'b1
) (
	input  wire logic      clk_in,
	input  wire logic      sys_rst_in,
	input  wire gica_req_t csr_req_in,
	input  wire logic      mach_state_enable_0_b60_in,
	input  wire logic      hyp_state_enable_0_b60_in,
	output var  gica_rsp_t csr_rsp_out
);

	// ----------------------------------------------------------------
	// Elaboration checks
	// ----------------------------------------------------------------
	localparam int IW = (NUM_ENTRIES > 1) ? $clog2(NUM_ENTRIES) : 1;
	localparam int EN = NUM_ENTRIES * GICA_NUM_ALIAS;
	localparam int EW = $clog2(EN);

	// Select bits above 31 would collide with the custom bit at 32-bit width
	// shared select width
	if (SEL_BITS < GICA_SEL_MIN_BITS || SEL_BITS > GICA_TOP32) begin : g_sel_bits_chk
		$error("SEL_BITS out of range");
	end
	// Entry window must fit inside the select value range
	if (NUM_ENTRIES < 2 || IMPL_BASE < 0 ||
			64'(IMPL_BASE + NUM_ENTRIES) > (64'h1 << SEL_BITS)) begin : g_entry_chk
		$error("Entry range out of range");
	end

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic                    sel_cust;
		logic [SEL_BITS-1:0]     sel_low;
		logic [EN-1:0][63:0]     ent;
		gica_rsp_t               rsp;
	} gica_state_t;

	gica_state_t st_ff;
	gica_state_t nxt_st;

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	logic                g_hit;
	logic                s_hit;
	logic                is_sel;
	logic                is_alias;
	logic [2:0]          al_num;
	logic                m_mode;
	logic                sel_impl;
	logic [SEL_BITS-1:0] sel_off;
	logic [EW-1:0]       flat;
	logic [63:0]         sel_val;

	// Alias index from the low register number bits
	always_comb begin
		is_sel   = 1'b0;
		is_alias = 1'b0;
		al_num   = 3'h0;
		g_hit    = 1'b0;
		s_hit    = 1'b0;
		case (csr_req_in.num)
			GICA_G_SEL: begin
				g_hit  = HYP_PRESENT;
				is_sel = 1'b1;
			end
			GICA_G_AL1, GICA_G_AL2, GICA_G_AL3: begin
				g_hit    = HYP_PRESENT;
				is_alias = 1'b1;
				al_num   = 3'(csr_req_in.num[1:0] - 2'h1);
			end
			GICA_G_AL4, GICA_G_AL5, GICA_G_AL6: begin
				g_hit    = HYP_PRESENT;
				is_alias = 1'b1;
				al_num   = 3'({1'b0, csr_req_in.num[1:0]} + 3'h2);
			end
			// supervisor pair redirected only while virtualised
			GICA_S_SEL: begin
				s_hit  = HYP_PRESENT & csr_req_in.virt;
				is_sel = 1'b1;
			end
			GICA_S_AL1, GICA_S_AL2, GICA_S_AL3: begin
				s_hit    = HYP_PRESENT & csr_req_in.virt;
				is_alias = 1'b1;
				al_num   = 3'(csr_req_in.num[1:0] - 2'h1);
			end
			GICA_S_AL4, GICA_S_AL5, GICA_S_AL6: begin
				s_hit    = HYP_PRESENT & csr_req_in.virt;
				is_alias = 1'b1;
				al_num   = 3'({1'b0, csr_req_in.num[1:0]} + 3'h2);
			end
			default: begin
				is_sel = 1'b0;
			end
		endcase
	end

	assign m_mode = (csr_req_in.priv == GICA_PRIV_M) & ~csr_req_in.virt;

	// custom values have no backing entries here
	assign sel_off  = st_ff.sel_low - SEL_BITS'(IMPL_BASE);
	assign sel_impl = ~st_ff.sel_cust &
		(st_ff.sel_low >= SEL_BITS'(IMPL_BASE)) &
		(sel_off < SEL_BITS'(NUM_ENTRIES));
	assign flat = EW'(EW'(sel_off[IW-1:0]) * EW'(GICA_NUM_ALIAS)) + EW'(al_num);

	// custom bit is stored apart and placed at the current top
	always_comb begin
		sel_val = 64'(st_ff.sel_low);
		if (csr_req_in.xlen64)
			sel_val[GICA_TOP64] = st_ff.sel_cust;
		else
			sel_val[GICA_TOP32] = st_ff.sel_cust;
	end

	// ----------------------------------------------------------------
	// Access check and dispatch
	// ----------------------------------------------------------------
	// Checks run in a fixed order so one request gives one cause
	// fixed check order
	always_comb begin
		nxt_st = st_ff;
		nxt_st.rsp = '0;
		nxt_st.rsp.valid = csr_req_in.valid;
		nxt_st.rsp.hit = csr_req_in.valid & (g_hit | s_hit);
		if (csr_req_in.valid && (g_hit || s_hit)) begin
			// machine bit gates both pairs, checked first
			if (MSTATEEN_IMP && !m_mode && !mach_state_enable_0_b60_in) begin
				nxt_st.rsp.illegal = 1'b1;
			end else if (g_hit && csr_req_in.virt) begin
				// guest touching its own copies directly
				nxt_st.rsp.virt_exc = 1'b1;
			end else if (g_hit && csr_req_in.priv == GICA_PRIV_U) begin
				// Plain user lacks hypervisor privilege
				nxt_st.rsp.illegal = 1'b1;
			end else if (s_hit && csr_req_in.priv == GICA_PRIV_U) begin
				nxt_st.rsp.virt_exc = 1'b1;
			end else if (s_hit && HSTATEEN_IMP && !hyp_state_enable_0_b60_in) begin
				// hypervisor bit closes the guest view
				nxt_st.rsp.virt_exc = 1'b1;
			end else if (is_alias && !sel_impl) begin
				nxt_st.rsp.illegal = 1'b1;
			end else if (is_alias && s_hit && !GUEST_IMPL) begin
				nxt_st.rsp.virt_exc = 1'b1;
			end else if (is_sel) begin
				// read and write at current width
				nxt_st.rsp.rdata = csr_req_in.xlen64 ? sel_val :
					{32'h0, sel_val[31:0]};
				if (csr_req_in.write) begin
					// low select bits kept as written
					nxt_st.sel_low = csr_req_in.wdata[SEL_BITS-1:0];
					nxt_st.sel_cust = csr_req_in.xlen64 ?
						csr_req_in.wdata[GICA_TOP64] :
						csr_req_in.wdata[GICA_TOP32];
				end
			end else begin
				// backing entry behaves as plain state
				nxt_st.rsp.rdata = csr_req_in.xlen64 ? st_ff.ent[flat] :
					{32'h0, st_ff.ent[flat][31:0]};
				if (csr_req_in.write) begin
					// Narrow writes keep the upper half
					nxt_st.ent[flat] = csr_req_in.xlen64 ? csr_req_in.wdata :
						{st_ff.ent[flat][63:32], csr_req_in.wdata[31:0]};
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	// Synchronous reset clears select, entries and response
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			st_ff.sel_cust <= GICA_RST_CUST;
			st_ff.sel_low  <= '0;
			st_ff.ent      <= {EN{GICA_RST_DATA}};
			st_ff.rsp      <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign csr_rsp_out = st_ff.rsp;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	logic wr_sel_ok;
	assign wr_sel_ok = csr_req_in.valid & csr_req_in.write & is_sel &
		g_hit & m_mode;

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (sys_rst_in);

	AST_MSTATEEN_ILLEGAL: assert property (
		csr_req_in.valid && (g_hit || s_hit) && MSTATEEN_IMP && !m_mode &&
		!mach_state_enable_0_b60_in |=> csr_rsp_out.illegal && !csr_rsp_out.virt_exc)
		else $error("Machine enable clear did not give illegal");

	AST_MMODE_FREE: assert property (
		csr_req_in.valid && g_hit && is_sel && m_mode
		|=> csr_rsp_out.valid && !csr_rsp_out.illegal && !csr_rsp_out.virt_exc)
		else $error("Machine mode select access faulted");

	AST_GUEST_DIRECT: assert property (
		csr_req_in.valid && g_hit && csr_req_in.virt &&
		(mach_state_enable_0_b60_in || !MSTATEEN_IMP) |=> csr_rsp_out.virt_exc)
		else $error("Guest direct access missed virtual fault");

	AST_GUEST_USER_SUP: assert property (
		csr_req_in.valid && s_hit && csr_req_in.priv == GICA_PRIV_U &&
		(mach_state_enable_0_b60_in || !MSTATEEN_IMP)
		|=> csr_rsp_out.virt_exc && !csr_rsp_out.illegal)
		else $error("Guest user supervisor access missed virtual fault");

	AST_HSTATEEN_VIRT: assert property (
		csr_req_in.valid && s_hit && HSTATEEN_IMP && !hyp_state_enable_0_b60_in &&
		(mach_state_enable_0_b60_in || !MSTATEEN_IMP) |=> csr_rsp_out.virt_exc)
		else $error("Hypervisor enable clear missed virtual fault");

	AST_RSP_TIMING: assert property (
		csr_req_in.valid |=> csr_rsp_out.valid ##1 ($past(csr_req_in.valid)
		== csr_rsp_out.valid))
		else $error("Response not one cycle after request");

	AST_SEL_STORE: assert property (
		wr_sel_ok |=> st_ff.sel_low == $past(csr_req_in.wdata[SEL_BITS-1:0]))
		else $error("Select write not stored");

	AST_CUST_TOP: assert property (
		csr_req_in.valid && g_hit && is_sel && m_mode && !csr_req_in.write
		|=> csr_rsp_out.rdata[$past(csr_req_in.xlen64) ? GICA_TOP64 : GICA_TOP32]
		== st_ff.sel_cust)
		else $error("Custom bit not at current top");

	AST_UNIMPL_ILLEGAL: assert property (
		csr_req_in.valid && g_hit && is_alias && m_mode && st_ff.sel_cust
		|=> csr_rsp_out.illegal)
		else $error("Custom select alias access not illegal");

	AST_MISS_QUIET: assert property (
		csr_req_in.valid && !g_hit && !s_hit |=> csr_rsp_out.valid && !csr_rsp_out.hit &&
		!csr_rsp_out.illegal && !csr_rsp_out.virt_exc && csr_rsp_out.rdata == '0)
		else $error("Miss answered with more than a bare valid");

	AST_SUP_PLAIN: assert property (
		csr_req_in.valid && !csr_req_in.virt && csr_req_in.num[11:8] == 4'h1
		|=> !csr_rsp_out.hit)
		else $error("Supervisor pair claimed outside a guest");

	AST_HYP_SEL_FREE: assert property (
		csr_req_in.valid && g_hit && is_sel && !csr_req_in.virt && csr_req_in.priv == GICA_PRIV_S &&
		!hyp_state_enable_0_b60_in && (mach_state_enable_0_b60_in || !MSTATEEN_IMP)
		|=> !csr_rsp_out.illegal && !csr_rsp_out.virt_exc)
		else $error("Hypervisor enable gated hypervisor access");

	AST_NARROW_READ: assert property (
		csr_req_in.valid && !csr_req_in.xlen64 |=> csr_rsp_out.rdata[63:32] == 32'h0)
		else $error("Narrow read carried upper half");

endmodule

`default_nettype wire

// ### test/gica_pipe_model.sv
// Hart pipeline model that issues register requests and collects answers
`timescale 1ns/10ps
`default_nettype none

module gica_pipe_model
	import gica_pkg::*;
(
	input  wire gica_rsp_t rsp_in,
	input  wire logic      clk_in,
	output var  gica_req_t req_out
);
	initial begin
		req_out = '0;
	end

	// One request strobed for a cycle; answer looked for in a bounded window
	task automatic access(input logic wr, input logic [11:0] num, input logic [63:0] wd,
		input logic [1:0] pv, input logic vt, input logic x64,
		output logic [66:0] got, output bit ok);
		ok = 1'b0;
		got = '0;
		@(posedge clk_in);
		req_out <= '{valid: 1'b1, write: wr, num: num, wdata: wd, priv: pv, virt: vt,
			xlen64: x64};
		@(posedge clk_in);
		// Released lines carry inverted values so stale data never looks valid
		req_out.valid <= 1'b0;
		req_out.num   <= ~num;
		req_out.wdata <= ~wd;
		for (int k = 0; k < 4; k++) begin
			#1;
			if (rsp_in.valid === 1'b1) begin
				got = {rsp_in.hit, rsp_in.illegal, rsp_in.virt_exc, rsp_in.rdata};
				ok  = 1'b1;
				break;
			end
			@(posedge clk_in);
		end
	endtask
endmodule
`default_nettype wire

// ### test/gica_top_tb_top.sv
// Self-checking bench for the guest indirect register window
`timescale 1ns/10ps
`default_nettype none

module gica_top_tb_top
	import gica_pkg::*;
;
	// ----------------------------------------------------------------
	// Signals and expected answer codes
	// ----------------------------------------------------------------
	localparam logic [66:0] ILL = {3'h6, 64'h0};
	localparam logic [66:0] VEX = {3'h5, 64'h0};
	localparam logic [66:0] WOK = {3'h4, 64'h0};
	localparam logic [11:0] GAL [6] = '{GICA_G_AL1, GICA_G_AL2, GICA_G_AL3,
		GICA_G_AL4, GICA_G_AL5, GICA_G_AL6};
	localparam logic [11:0] SAL [6] = '{GICA_S_AL1, GICA_S_AL2, GICA_S_AL3,
		GICA_S_AL4, GICA_S_AL5, GICA_S_AL6};
	logic        clk_in;
	logic        sys_rst_in;
	logic        b60m;
	logic        b60h;
	gica_req_t   csr_req;
	gica_rsp_t   csr_rsp;
	int          failures;
	int          check_count;
	logic [66:0] got;
	bit          ok;

	gica_top i_gica_top (
		.clk_in                     (clk_in),
		.sys_rst_in                 (sys_rst_in),
		.csr_req_in                 (csr_req),
		.mach_state_enable_0_b60_in (b60m),
		.hyp_state_enable_0_b60_in  (b60h),
		.csr_rsp_out                (csr_rsp)
	);

	gica_pipe_model i_gica_pipe_model (
		.rsp_in  (csr_rsp),
		.clk_in  (clk_in),
		.req_out (csr_req)
	);

	// 20 MHz clock
	initial begin
		clk_in = 1'b0;
		forever #25 clk_in = ~clk_in;
	end

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic end_of_test();
		if (failures == 0 && check_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic check(input logic [66:0] seen, input logic [66:0] exp);
		check_count++;
		if (seen !== exp) begin
			failures++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Write data echo is not compared, only the status bits of a write
	task automatic acc(input logic wr, input logic [11:0] num, input logic [63:0] wd,
		input logic [1:0] pv, input logic vt, input logic x64, input logic [66:0] exp);
		i_gica_pipe_model.access(wr, num, wd, pv, vt, x64, got, ok);
		if (!ok) begin
			failures++;
			end_of_test();
		end
		if (wr) begin
			got[63:0] = 64'h0;
		end
		check(got, exp);
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		sys_rst_in = 1'b1;
		b60m = 1'b1;
		b60h = 1'b1;
		failures = 0;
		check_count = 0;
		repeat (3) @(posedge clk_in);
		sys_rst_in <= 1'b0;
		acc(0, GICA_G_SEL, 64'h0, GICA_PRIV_M, 0, 1, WOK);
		acc(1, GICA_G_SEL, 64'hfff, GICA_PRIV_M, 0, 1, WOK);
		acc(0, GICA_G_SEL, 64'h0, GICA_PRIV_M, 0, 1, {3'h4, 64'hfff});
		acc(1, GICA_G_SEL, 64'h8000_0000_0000_0001, GICA_PRIV_M, 0, 1, WOK);
		acc(0, GICA_G_SEL, 64'h0, GICA_PRIV_M, 0, 0, {3'h4, 64'h8000_0001});
		acc(0, GICA_G_SEL, 64'h0, GICA_PRIV_M, 0, 1, {3'h4, 64'h8000_0000_0000_0001});
		acc(0, GICA_G_AL1, 64'h0, GICA_PRIV_M, 0, 1, ILL);
		// Fill all six aliases of entry one from the hypervisor, read back as guest
		acc(1, GICA_G_SEL, 64'h1, GICA_PRIV_S, 0, 1, WOK);
		for (int i = 0; i < 6; i++) begin
			acc(1, GAL[i], 64'h0123_4567_89ab_cd00 + i, GICA_PRIV_S, 0, 1, WOK);
		end
		for (int i = 0; i < 6; i++) begin
			acc(0, SAL[i], 64'h0, GICA_PRIV_S, 1, 1, {3'h4, 64'h0123_4567_89ab_cd00 + i});
		end
		acc(0, GICA_G_AL1, 64'h0, GICA_PRIV_S, 1, 1, VEX);
		acc(0, GICA_G_SEL, 64'h0, GICA_PRIV_U, 1, 1, VEX);
		acc(0, GICA_S_SEL, 64'h0, GICA_PRIV_U, 1, 1, VEX);
		acc(0, GICA_S_AL1, 64'h0, GICA_PRIV_U, 0, 1, 67'h0);
		// Narrow write touches only the low half of the entry
		acc(1, GICA_S_AL1, 64'hffff_ffff_dead_beef, GICA_PRIV_S, 1, 0, WOK);
		acc(0, GICA_S_AL1, 64'h0, GICA_PRIV_S, 1, 1, {3'h4, 64'h0123_4567_dead_beef});
		acc(0, GICA_S_AL1, 64'h0, GICA_PRIV_S, 1, 0, {3'h4, 64'h0000_0000_dead_beef});
		acc(1, GICA_G_SEL, 64'h4, GICA_PRIV_M, 0, 1, WOK);
		acc(0, GICA_G_AL2, 64'h0, GICA_PRIV_M, 0, 1, ILL);
		// Machine enable bit cleared
		@(posedge clk_in);
		b60m <= 1'b0;
		acc(0, GICA_G_SEL, 64'h0, GICA_PRIV_S, 0, 1, ILL);
		acc(0, GICA_S_SEL, 64'h0, GICA_PRIV_S, 1, 1, ILL);
		acc(0, GICA_G_SEL, 64'h0, GICA_PRIV_S, 1, 1, ILL);
		acc(0, GICA_G_SEL, 64'h0, GICA_PRIV_M, 0, 1, {3'h4, 64'h4});
		// Hypervisor enable bit cleared
		@(posedge clk_in);
		b60m <= 1'b1;
		b60h <= 1'b0;
		acc(0, GICA_S_SEL, 64'h0, GICA_PRIV_S, 1, 1, VEX);
		acc(0, GICA_G_SEL, 64'h0, GICA_PRIV_S, 0, 1, {3'h4, 64'h4});
		@(posedge clk_in);
		b60h <= 1'b1;
		acc(0, GICA_S_SEL, 64'h0, GICA_PRIV_S, 1, 1, {3'h4, 64'h4});
		// Narrow select write lifts the custom bit to the 64-bit top
		acc(1, GICA_G_SEL, 64'h8000_0002, GICA_PRIV_M, 0, 0, WOK);
		acc(0, GICA_G_SEL, 64'h0, GICA_PRIV_M, 0, 1, {3'h4, 64'h8000_0000_0000_0002});
		// Reset in mid-run clears select, custom bit and entries
		@(posedge clk_in);
		sys_rst_in <= 1'b1;
		@(posedge clk_in);
		sys_rst_in <= 1'b0;
		acc(0, GICA_G_SEL, 64'h0, GICA_PRIV_M, 0, 1, WOK);
		acc(1, GICA_G_SEL, 64'h1, GICA_PRIV_S, 0, 1, WOK);
		acc(0, GICA_G_AL1, 64'h0, GICA_PRIV_S, 0, 1, WOK);
		end_of_test();
	end
endmodule
`default_nettype wire
